// >>> include/codec_frame_pkg.sv
package codec_frame_pkg;
  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;             // serial word length
  localparam int DAC_W = 15;              // dac sample width
  localparam int REG_W = 8;               // control register width
  localparam int REQ_BIT = 0;             // secondary request flag in primary input word
  localparam int CMD_RD_BIT = 15;         // secondary word: 1 = read, 0 = write
  localparam int ADDR_HI = 14;            // secondary word address field, upper bit
  localparam int ADDR_LO = 13;            // secondary word address field, lower bit
  localparam logic [1:0] ADDR_NULL = 2'h0;  // pseudo-register, null_command
  localparam logic [1:0] ADDR_CTRL1 = 2'h1; // control register 1
  localparam logic [1:0] ADDR_CTRL2 = 2'h2; // control register 2
  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int OVF_BIT = 0;             // ctrl2: adc overflow flag
  localparam int ALOOP_BIT = 4;           // ctrl1: analog loopback
  localparam int DLOOP_BIT = 5;           // ctrl1: digital loopback
  localparam int PD_BIT = 6;              // ctrl1: software power-down
  localparam logic [7:0] CTRL1_RST = 8'h00; // ctrl1 default
  localparam logic [7:0] CTRL2_RST = 8'h00; // ctrl2 default
  // ----------------------------------------------------------------
  // frame timing, in shift-clock periods
  // ----------------------------------------------------------------
  localparam int FRAME_SCLKS_DEF = 256;   // shift clocks per conversion period
  localparam int SEC_START = 128;         // secondary frame offset from primary start
  localparam int CMD_IDX = 2;             // bit index by which read flag and address are in
  localparam int RD_LOAD_IDX = 8;         // bit index where read data starts going out
  localparam int LAST_IDX = 15;           // last bit index of a word
endpackage : codec_frame_pkg

// >>> hdl/codec_frame_port.sv
`timescale 1ns/1ps
module codec_frame_port import codec_frame_pkg::*; #(
  parameter int FRAME_SCLKS = FRAME_SCLKS_DEF, // shift clocks per conversion period
  parameter int SLOT_W = 9                     // width of the slot counter
) (
  input wire logic CLK_SYS_I,                  // system clock, 250 MHz
  input wire logic SYS_RST_I,                  // synchronous reset, active high
  input wire logic LINK_CLK_I,                 // codec master clock, shift clock source
  input wire logic STRAP_FS_HIGH_I,            // static strap: 1 pulse sync, 0 low sync
  input wire logic [WORD_W-1:0] ADC_SAMPLE_I,  // adc sample from converter
  input wire logic ADC_VALID_I,                // one-cycle strobe with adc sample
  input wire logic ADC_OVERFLOW_I,             // one-cycle pulse on adc overflow
  output logic [DAC_W-1:0] DAC_SAMPLE_O,       // dac sample received from host
  output logic DAC_VALID_O,                    // one-cycle strobe with dac sample
  output logic [REG_W-1:0] CTRL1_O,            // mirror of control register 1
  output logic [REG_W-1:0] CTRL2_O,            // mirror of control register 2
  output logic POWER_DOWN_O,                   // software power-down active
  output logic SHIFT_CLOCK_O,                  // shift_clock pin
  output logic FRAME_SYNC_O,                   // frame_sync pin
  output logic SAMPLE_OUT_LINE_O,              // sample_out_line pin
  input wire logic SAMPLE_IN_LINE_I            // sample_in_line pin
);

  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(FRAME_SCLKS - 1);
  localparam logic [SLOT_W-1:0] SLOT_SEC = SLOT_W'(SEC_START);

  // ----------------------------------------------------------------
  // position of a slot inside the frames: {valid, secondary, bit index}
  // ----------------------------------------------------------------
  function automatic logic [5:0] frame_pos(input logic [SLOT_W-1:0] s, input logic fsh, input logic sec_en);
    logic [SLOT_W-1:0] p0;
    logic [SLOT_W-1:0] p1;
    p0 = s - SLOT_W'(fsh);
    p1 = s - SLOT_SEC - SLOT_W'(fsh);
    if (s >= SLOT_W'(fsh) && p0 < SLOT_W'(WORD_W)) begin
      frame_pos = {2'b10, p0[3:0]};
    end else if (sec_en && s >= SLOT_SEC + SLOT_W'(fsh) && p1 < SLOT_W'(WORD_W)) begin
      frame_pos = {2'b11, p1[3:0]};
    end else begin
      frame_pos = 6'h00;
    end
  endfunction : frame_pos

  // ----------------------------------------------------------------
  // link domain declarations
  // ----------------------------------------------------------------
  logic lrst_meta_r, lrst_r;
  logic strap_meta_r, strap_r, fs_high_r;
  logic sclk_r, fs_r, sec_r;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic [5:0] pos_cur, pos_nxt, prev_pos_r;
  logic [WORD_W-1:0] tx_sh_r, rx_sh_r, word_in, adc_word_r;
  logic din_meta_r, din_r;
  logic rd_r;
  logic [1:0] addr_r;
  logic [REG_W-1:0] ctrl1_r, rd_val;
  logic [REG_W-1:1] ctrl2_r;
  logic ovf_r;
  logic [DAC_W-1:0] dac_word_r;
  logic dac_tgl_r, reg_tgl_r;
  logic adc_t_meta_r, adc_t_s2_r, adc_t_s3_r;
  logic ovf_t_meta_r, ovf_t_s2_r, ovf_t_s3_r;
  logic rise, fall, halt, pd, fs_nxt, word_done, cmd_done, wr, ovf_evt, ovf_rd_clr;

  // ----------------------------------------------------------------
  // system domain declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] adc_hold_r;
  logic adc_tgl_r, ovf_tgl_r;
  logic dac_t_meta_r, dac_t_s2_r, dac_t_s3_r;
  logic reg_t_meta_r, reg_t_s2_r, reg_t_s3_r;
  logic [DAC_W-1:0] dac_out_r;
  logic dac_vld_r;
  logic [REG_W-1:0] ctrl1_sys_r, ctrl2_sys_r;

  // ----------------------------------------------------------------
  // link reset, strap and pin synchronisers
  // ----------------------------------------------------------------
  // reset reaches the link side through two flops; strap caught while held
  always_ff @(posedge LINK_CLK_I) begin
    lrst_meta_r <= SYS_RST_I;
    lrst_r <= lrst_meta_r;
  end

  always_ff @(posedge LINK_CLK_I) begin
    strap_meta_r <= STRAP_FS_HIGH_I;
    strap_r <= strap_meta_r;
    din_meta_r <= SAMPLE_IN_LINE_I;
    din_r <= din_meta_r;
  end

  // strap is static, so sampling it only during reset is enough
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      fs_high_r <= strap_r;
    end
  end

  // ----------------------------------------------------------------
  // shift clock and slot counter
  // ----------------------------------------------------------------
  assign pd = ctrl1_r[PD_BIT];
  assign halt = lrst_r | pd;
  assign rise = ~sclk_r;                          // this edge raises the shift clock
  assign fall = sclk_r;
  assign slot_nxt = (slot_r == SLOT_LAST) ? '0 : slot_r + 1'b1;
  assign pos_cur = frame_pos(slot_r, fs_high_r, sec_r);
  assign pos_nxt = frame_pos(slot_nxt, fs_high_r, sec_r);

  // shift clock is the link clock halved; power-down stops it and the counters
  always_ff @(posedge LINK_CLK_I) begin
    if (halt) begin
      sclk_r <= 1'b0;
      slot_r <= SLOT_LAST;
    end else begin
      sclk_r <= ~sclk_r;
      if (rise) begin
        slot_r <= slot_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sync
  // ----------------------------------------------------------------
  always_comb begin
    if (fs_high_r) begin
      fs_nxt = (slot_nxt == '0) || (sec_r && slot_nxt == SLOT_SEC);
    end else begin
      fs_nxt = ~pos_nxt[5];
    end
  end

  // idle level depends on the strap: low in pulse mode, high in low-sync mode
  always_ff @(posedge LINK_CLK_I) begin
    if (halt) begin
      fs_r <= ~(lrst_r ? strap_r : fs_high_r);
    end else if (rise) begin
      fs_r <= fs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  always_comb begin
    unique case (addr_r)
      ADDR_CTRL1: rd_val = ctrl1_r;
      ADDR_CTRL2: rd_val = {ctrl2_r, ovf_r};
      default: rd_val = '0;
    endcase
  end

  // read data is loaded at bit 8 because the command bits arrive first
  always_ff @(posedge LINK_CLK_I) begin
    if (halt) begin
      tx_sh_r <= '0;
    end else if (rise) begin
      if (pos_nxt[5] && pos_nxt[3:0] == 4'h0) begin
        tx_sh_r <= pos_nxt[4] ? '0 : adc_word_r;
      end else if (pos_nxt[5] && pos_nxt[4] && pos_nxt[3:0] == 4'(RD_LOAD_IDX) && rd_r) begin
        tx_sh_r <= {rd_val, 8'h00};
      end else begin
        tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  // a bit launched in one slot is read from the synchroniser in the next slot
  always_ff @(posedge LINK_CLK_I) begin
    if (halt) begin
      prev_pos_r <= '0;
    end else if (rise) begin
      prev_pos_r <= pos_cur;
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (halt) begin
      rx_sh_r <= '0;
    end else if (fall && prev_pos_r[5]) begin
      rx_sh_r <= {rx_sh_r[WORD_W-2:0], din_r};
    end
  end

  assign word_in = {rx_sh_r[WORD_W-2:0], din_r};
  assign word_done = fall && prev_pos_r[5] && prev_pos_r[3:0] == 4'(LAST_IDX) && !halt;
  assign cmd_done = fall && prev_pos_r[5] && prev_pos_r[4] && prev_pos_r[3:0] == 4'(CMD_IDX) && !halt;
  assign wr = word_done && prev_pos_r[4] && !word_in[CMD_RD_BIT] && word_in[ADDR_HI:ADDR_LO] != ADDR_NULL;

  // ----------------------------------------------------------------
  // secondary request and command decode
  // ----------------------------------------------------------------
  always_ff @(posedge LINK_CLK_I) begin
    if (halt) begin
      sec_r <= 1'b0;
    end else if (word_done && !prev_pos_r[4]) begin
      sec_r <= word_in[REQ_BIT];
    end else if (rise && slot_nxt == '0) begin
      sec_r <= 1'b0;
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      rd_r <= 1'b0;
      addr_r <= ADDR_NULL;
    end else if (cmd_done) begin
      rd_r <= rx_sh_r[1];
      addr_r <= {rx_sh_r[0], din_r};
    end
  end

  // received dac sample goes to the system side with a toggle
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      dac_word_r <= '0;
      dac_tgl_r <= 1'b0;
    end else if (word_done && !prev_pos_r[4]) begin
      dac_word_r <= word_in[WORD_W-1:1];
      dac_tgl_r <= ~dac_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // power-down does not touch these; only reset or a serial write does
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST[REG_W-1:1];
    end else if (wr) begin
      if (word_in[ADDR_HI:ADDR_LO] == ADDR_CTRL1) begin
        ctrl1_r <= word_in[REG_W-1:0];
      end
      if (word_in[ADDR_HI:ADDR_LO] == ADDR_CTRL2) begin
        ctrl2_r <= word_in[REG_W-1:1];
      end
    end
  end

  // overflow flag: a new overflow beats a clearing read in the same cycle
  assign ovf_evt = ovf_t_s2_r ^ ovf_t_s3_r;
  assign ovf_rd_clr = rise && !halt && pos_nxt[5] && pos_nxt[4] && pos_nxt[3:0] == 4'(RD_LOAD_IDX)
                      && rd_r && addr_r == ADDR_CTRL2;

  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      ovf_r <= CTRL2_RST[OVF_BIT];
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
    end else if (ovf_rd_clr) begin
      ovf_r <= 1'b0;
    end
  end

  // announce any register change to the system side
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      reg_tgl_r <= 1'b0;
    end else if (wr || ovf_evt || ovf_rd_clr) begin
      reg_tgl_r <= ~reg_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // crossings into the link domain
  // ----------------------------------------------------------------
  // the held sample is stable long before its toggle is seen here
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r) begin
      adc_t_meta_r <= 1'b0;
      adc_t_s2_r <= 1'b0;
      adc_t_s3_r <= 1'b0;
      ovf_t_meta_r <= 1'b0;
      ovf_t_s2_r <= 1'b0;
      ovf_t_s3_r <= 1'b0;
      adc_word_r <= '0;
    end else begin
      adc_t_meta_r <= adc_tgl_r;
      adc_t_s2_r <= adc_t_meta_r;
      adc_t_s3_r <= adc_t_s2_r;
      ovf_t_meta_r <= ovf_tgl_r;
      ovf_t_s2_r <= ovf_t_meta_r;
      ovf_t_s3_r <= ovf_t_s2_r;
      if (adc_t_s2_r ^ adc_t_s3_r) begin
        adc_word_r <= adc_hold_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      adc_hold_r <= '0;
      adc_tgl_r <= 1'b0;
      ovf_tgl_r <= 1'b0;
    end else begin
      if (ADC_VALID_I) begin
        adc_hold_r <= ADC_SAMPLE_I;
        adc_tgl_r <= ~adc_tgl_r;
      end
      if (ADC_OVERFLOW_I) begin
        ovf_tgl_r <= ~ovf_tgl_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      dac_t_meta_r <= 1'b0;
      dac_t_s2_r <= 1'b0;
      dac_t_s3_r <= 1'b0;
      dac_out_r <= '0;
      dac_vld_r <= 1'b0;
    end else begin
      dac_t_meta_r <= dac_tgl_r;
      dac_t_s2_r <= dac_t_meta_r;
      dac_t_s3_r <= dac_t_s2_r;
      dac_vld_r <= dac_t_s2_r ^ dac_t_s3_r;
      if (dac_t_s2_r ^ dac_t_s3_r) begin
        dac_out_r <= dac_word_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      reg_t_meta_r <= 1'b0;
      reg_t_s2_r <= 1'b0;
      reg_t_s3_r <= 1'b0;
      ctrl1_sys_r <= CTRL1_RST;
      ctrl2_sys_r <= CTRL2_RST;
    end else begin
      reg_t_meta_r <= reg_tgl_r;
      reg_t_s2_r <= reg_t_meta_r;
      reg_t_s3_r <= reg_t_s2_r;
      if (reg_t_s2_r ^ reg_t_s3_r) begin
        ctrl1_sys_r <= ctrl1_r;
        ctrl2_sys_r <= {ctrl2_r, ovf_r};
      end
    end
  end

  // outputs
  assign DAC_SAMPLE_O = dac_out_r;
  assign DAC_VALID_O = dac_vld_r;
  assign CTRL1_O = ctrl1_sys_r;
  assign CTRL2_O = ctrl2_sys_r;
  assign POWER_DOWN_O = ctrl1_sys_r[PD_BIT];
  assign SHIFT_CLOCK_O = sclk_r;
  assign FRAME_SYNC_O = fs_r;
  assign SAMPLE_OUT_LINE_O = tx_sh_r[WORD_W-1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [6:0] fs_low_cnt_r;
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r || fs_r) begin
      fs_low_cnt_r <= '0;
    end else begin
      fs_low_cnt_r <= fs_low_cnt_r + 7'h01;
    end
  end

  default clocking cb_link @(posedge LINK_CLK_I); endclocking
  default disable iff (lrst_r);

  property p_high_pulse;
    fs_high_r && $rose(fs_r) |=> fs_r ##1 !fs_r;
  endproperty
  a_high_pulse: assert property (p_high_pulse) else $error("high-mode sync not one shift clock");

  property p_low_span;
    !fs_high_r && $rose(fs_r) |-> fs_low_cnt_r == 7'h20;
  endproperty
  a_low_span: assert property (p_low_span) else $error("low-mode sync not sixteen bits long");

  property p_sec_high;
    fs_high_r && sec_r && !pd && rise && slot_r == SLOT_SEC - 1'b1 |=> fs_r ##2 !fs_r;
  endproperty
  a_sec_high: assert property (p_sec_high) else $error("secondary sync pulse missing at 128");

  property p_sec_low;
    !fs_high_r && sec_r && !pd && rise && slot_r == SLOT_SEC - 1'b1 |=> !fs_r;
  endproperty
  a_sec_low: assert property (p_sec_low) else $error("secondary low sync missing at 128");

  property p_no_sec;
    !sec_r && slot_r >= SLOT_SEC && slot_r < SLOT_SEC + 8'h11 |-> fs_r == !fs_high_r;
  endproperty
  a_no_sec: assert property (p_no_sec) else $error("secondary frame without request");

  property p_adc_msb;
    !sclk_r ##1 sclk_r && pos_cur[5] && !pos_cur[4] && pos_cur[3:0] == 4'h0
      |-> SAMPLE_OUT_LINE_O == adc_word_r[WORD_W-1];
  endproperty
  a_adc_msb: assert property (p_adc_msb) else $error("adc msb not first on line");

  property p_pd_hold;
    pd |=> slot_r == SLOT_LAST && !sclk_r && $stable(ctrl1_r) && $stable(ctrl2_r);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down did not stop counters or kept no regs");

  property p_ovf;
    (ovf_evt |=> ovf_r) and (ovf_rd_clr && !ovf_evt |=> !ovf_r);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag set or clear wrong");

  property p_null;
    word_done && prev_pos_r[4] && word_in[ADDR_HI:ADDR_LO] == ADDR_NULL |=> $stable(ctrl1_r) && $stable(ctrl2_r);
  endproperty
  a_null: assert property (p_null) else $error("null command changed a register");

  property p_wr_zero;
    pos_cur[5] && pos_cur[4] && !rd_r |-> !SAMPLE_OUT_LINE_O;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("secondary write returned nonzero");

  c_secondary: cover property (sec_r && rise && slot_r == SLOT_SEC);
  c_write: cover property (wr);
  c_ovf_read: cover property (ovf_rd_clr && ovf_r);
  c_power_down: cover property ($rose(pd));

endmodule : codec_frame_port

// >>> dv/codec_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host serial port model
// ----------------------------------------
module codec_host_model (
  input wire logic sck_i,      // shift clock from the port
  input wire logic sync_i,     // frame sync, watched only
  input wire logic line_out_i, // sample out line
  input wire logic strap_i,    // strap level seen by the port
  output logic line_in_o       // sample in line
);
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  int start_q[$];
  int sck_n = 0;
  int bad = 0;
  int idx = -1;
  logic fell = 1'b0;
  logic [15:0] tx_w = 16'h0000;
  logic [15:0] rx_w = 16'h0000;
  initial line_in_o = 1'b0;
  // the port alone drives sync; a fall marks the first data slot
  always @(negedge sync_i) fell = 1'b1;
  // drive just after the rising edge that launches the matching output bit
  always @(posedge sck_i) begin
    #1;
    sck_n++;
    if (idx == 0 && sync_i !== ~strap_i) bad++;
    idx = (idx > 0) ? idx - 1 : -1;
    if (fell) begin
      fell = 1'b0;
      idx = 15;
      start_q.push_back(sck_n);
      tx_w = (tx_q.size() > 0) ? tx_q.pop_front() : 16'h0000;
    end
    if (idx >= 0 && sync_i !== 1'b0) bad++;
    // a released line toggles so a stale level cannot pass for data
    line_in_o = (idx >= 0) ? tx_w[idx] : ~line_in_o;
  end
  // capture mid-bit; word handed over at its last bit, the clock may stop after it
  always @(negedge sck_i) begin
    if (idx >= 0) begin
      rx_w[idx] = line_out_i;
      if (idx == 0) rx_q.push_back(rx_w);
    end
    else if (line_out_i !== 1'b0) bad++;
  end
endmodule : codec_host_model

// >>> dv/codec_serial_frame_port_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// serial frame port bench
// ----------------------------------------
module codec_serial_frame_port_bench;
  import codec_frame_pkg::*;
  localparam int FRAMES = 160; // shortened period keeps the run short
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b1;
  logic [WORD_W-1:0] adc_sample = 16'h0000;
  logic adc_valid = 1'b0;
  logic ovf_in = 1'b0;
  logic [DAC_W-1:0] dac_sample;
  logic dac_valid;
  logic [DAC_W-1:0] dac_seen = 15'h0000;
  logic [REG_W-1:0] ctrl1;
  logic [REG_W-1:0] ctrl2;
  logic power_down;
  logic sck;
  logic sync;
  logic line_out;
  logic line_in;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 78944;
  int c1 = 0;
  int c2 = 0;
  int ovf = 0;
  int last_p = -1;
  int n;
  initial forever #2 clk = ~clk;
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end
  codec_frame_port #(.FRAME_SCLKS(FRAMES)) DUT (.CLK_SYS_I(clk), .SYS_RST_I(sys_rst), .LINK_CLK_I(link_clk),
    .STRAP_FS_HIGH_I(strap), .ADC_SAMPLE_I(adc_sample), .ADC_VALID_I(adc_valid), .ADC_OVERFLOW_I(ovf_in),
    .DAC_SAMPLE_O(dac_sample), .DAC_VALID_O(dac_valid), .CTRL1_O(ctrl1), .CTRL2_O(ctrl2),
    .POWER_DOWN_O(power_down), .SHIFT_CLOCK_O(sck), .FRAME_SYNC_O(sync), .SAMPLE_OUT_LINE_O(line_out),
    .SAMPLE_IN_LINE_I(line_in));
  codec_host_model host (.sck_i(sck), .sync_i(sync), .line_out_i(line_out), .strap_i(strap), .line_in_o(line_in));
  // dac strobe lasts one cycle, so hold what it carried
  always @(posedge clk) if (dac_valid === 1'b1) dac_seen <= dac_sample;
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // strap changes only while reset is held
  task automatic do_reset(input logic s);
    @(posedge clk);
    #1;
    sys_rst = 1'b1;
    strap = s;
    repeat (4) @(posedge link_clk);
    repeat (4) @(posedge clk);
    check("idle sync", sync, !s);
    host.fell = 1'b0;
    last_p = -1;
    c1 = 0;
    c2 = 0;
    ovf = 0;
  endtask : do_reset
  // one conversion period: primary word, optional secondary word
  task automatic period(input logic rd, input logic [1:0] addr, input logic [7:0] data, input logic req,
                        input logic chk, input logic ov);
    logic [DAC_W-1:0] dac;
    logic [WORD_W-1:0] adc;
    logic [WORD_W-1:0] w;
    int exp;
    int t;
    int p;
    dac = $random(seed);
    adc = $random(seed);
    host.tx_q.push_back({dac, req});
    if (req) host.tx_q.push_back({rd, addr, 5'h00, data});
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    adc_sample = adc;
    adc_valid = 1'b1;
    ovf_in = ov;
    @(posedge clk);
    #1;
    adc_valid = 1'b0;
    ovf_in = 1'b0;
    for (t = 0; t < 40000 && host.rx_q.size() < 1 + req; t++) @(posedge clk);
    if (t == 40000) begin
      num_errors++;
      test_done();
    end
    // results cross back a few cycles after the link finishes
    repeat (200) @(posedge clk);
    w = host.rx_q.pop_front();
    if (chk) check("primary out", w, adc);
    check("dac sample", dac_seen, dac);
    p = host.start_q[host.start_q.size() - 1 - req];
    if (last_p >= 0) check("period", p - last_p, FRAMES);
    last_p = p;
    if (req) begin
      w = host.rx_q.pop_front();
      exp = 0;
      if (rd && addr == ADDR_CTRL1) exp = c1;
      if (rd && addr == ADDR_CTRL2) exp = c2 | ovf;
      check("secondary out", w, exp);
      check("secondary offset", host.start_q[$] - p, SEC_START);
      if (rd && addr == ADDR_CTRL2) ovf = 0;
      if (!rd && addr == ADDR_CTRL1) c1 = data;
      if (!rd && addr == ADDR_CTRL2) c2 = data & 8'hFE;
    end
    if (ov) ovf = 1;
    check("ctrl1", ctrl1, c1);
    check("ctrl2", ctrl2, c2 | ovf);
    check("power down", power_down, c1[6]);
    check("host view", host.bad, 0);
  endtask : period
  initial begin
    do_reset(1'b1);
    period(1'b0, ADDR_CTRL1, 8'h30, 1'b1, 1'b0, 1'b1);
    period(1'b0, ADDR_NULL, 8'hFF, 1'b1, 1'b1, 1'b0);
    period(1'b0, ADDR_NULL, 8'h00, 1'b0, 1'b1, 1'b0);
    period(1'b1, ADDR_CTRL2, 8'h00, 1'b1, 1'b1, 1'b0);
    period(1'b1, ADDR_CTRL2, 8'h00, 1'b1, 1'b1, 1'b0);
    period(1'b0, ADDR_CTRL1, 8'h70, 1'b1, 1'b1, 1'b0);
    n = host.sck_n;
    repeat (2000) @(posedge clk);
    check("stopped clock", host.sck_n, n);
    check("ctrl1 kept", ctrl1, 8'h70);
    do_reset(1'b0);
    period(1'b1, ADDR_CTRL1, 8'h00, 1'b1, 1'b0, 1'b0);
    test_done();
  end
endmodule : codec_serial_frame_port_bench
